// ---- idd_pkg.sv ----
// package of constants for the ide drive select decoder
package idd_pkg;
  // ==========================================
  // address decode
  localparam logic [9:0] PRI_CMD_BASE = 10'h1F0;
  localparam logic [9:0] SEC_CMD_BASE = 10'h170;
  localparam logic [9:0] PRI_CTL_LO = 10'h3F6;
  localparam logic [9:0] PRI_CTL_HI = 10'h3F7;
  localparam logic [9:0] SEC_CTL_LO = 10'h376;
  localparam logic [9:0] SEC_CTL_HI = 10'h377;
  localparam logic [9:0] CMD_MASK = 10'h3F8;
  // ==========================================
  // operating modes of the controller
  typedef enum logic [1:0] {MODE_AT, MODE_ILLEGAL, MODE_PS2, MODE_M30} idd_mode_type;
  // ==========================================
  // reset values
  localparam logic OUT_INACTIVE = 1'b1;
  localparam logic SYNC_RESET_VAL = 1'b0;
endpackage : idd_pkg

// ---- idd_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module idd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
    if (!rst_n)
    begin
      meta_d = {WIDTH{idd_pkg::SYNC_RESET_VAL}};
      sync_d = {WIDTH{idd_pkg::SYNC_RESET_VAL}};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;
endmodule : idd_sync

// ---- idd_decode.sv ----
// ide drive select decoder: chip selects, bit 7 pass-through, byte latch enables
`timescale 1ns/1ps
module idd_decode (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [9:0] host_addr,
  input wire logic host_ior_n,
  input wire logic host_iow_n,
  input wire logic host_aen,
  input wire logic host_d7_in,
  output logic host_d7_out,
  output logic host_d7_oe_n,
  input wire logic drive_data_bit7_in,
  output logic drive_data_bit7_out,
  output logic drive_data_bit7_oe_n,
  input wire logic drive_iocs16_n,
  input wire logic ide_enable,
  input wire logic secondary_sel,
  input wire idd_pkg::idd_mode_type op_mode,
  output logic drive_chip_select_0_n,
  output logic drive_chip_select_1_n,
  output logic high_byte_latch_enable_n,
  output logic low_byte_latch_enable_n
);
  // ==========================================
  // pin synchronisers
  logic [14:0] pins_raw;
  logic [14:0] pins_s;
  logic [9:0] addr_s;
  logic ior_n_s;
  logic iow_n_s;
  logic aen_s;
  logic iocs16_n_s;
  logic hd7_s;
  logic dd7_s;

  assign pins_raw = {host_addr, host_ior_n, host_iow_n, host_aen, drive_iocs16_n,
                     host_d7_in};

  idd_sync #(.WIDTH(15)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic dd7_meta_q;
  logic dd7_meta_d;
  logic dd7_sync_q;
  logic dd7_sync_d;

  always_comb
  begin
    dd7_meta_d = rst_n ? drive_data_bit7_in : idd_pkg::SYNC_RESET_VAL;
    dd7_sync_d = rst_n ? dd7_meta_q : idd_pkg::SYNC_RESET_VAL;
  end

  always_ff @(posedge ref_clk)
  begin
    dd7_meta_q <= dd7_meta_d;
    dd7_sync_q <= dd7_sync_d;
  end

  assign addr_s = pins_s[14:5];
  assign ior_n_s = pins_s[4];
  assign iow_n_s = pins_s[3];
  assign aen_s = pins_s[2];
  assign iocs16_n_s = pins_s[1];
  assign hd7_s = pins_s[0];
  assign dd7_s = dd7_sync_q;

  // ==========================================
  // address decode
  function automatic logic hit_range(input logic [9:0] a, input logic [9:0] lo,
                                     input logic [9:0] hi);
    hit_range = (a >= lo) && (a <= hi);
  endfunction : hit_range

  logic cyc_valid;
  logic rd_cyc;
  logic cmd_hit;
  logic ctl_hit;
  logic ctl_lo_hit;
  logic [9:0] cmd_base;
  logic [9:0] ctl_lo;
  logic [9:0] ctl_hi;

  always_comb
  begin
    cmd_base = secondary_sel ? idd_pkg::SEC_CMD_BASE : idd_pkg::PRI_CMD_BASE;
    ctl_lo = secondary_sel ? idd_pkg::SEC_CTL_LO : idd_pkg::PRI_CTL_LO;
    ctl_hi = secondary_sel ? idd_pkg::SEC_CTL_HI : idd_pkg::PRI_CTL_HI;
    cyc_valid = !aen_s && (ior_n_s ^ iow_n_s);
    rd_cyc = !ior_n_s;
    cmd_hit = ((addr_s & idd_pkg::CMD_MASK) == cmd_base);
    ctl_hit = hit_range(addr_s, ctl_lo, ctl_hi);
    ctl_lo_hit = hit_range(addr_s, ctl_lo, ctl_lo);
  end

  // ==========================================
  // output registers
  logic cs0_n_q, cs0_n_d;
  logic cs1_n_q, cs1_n_d;
  logic hi_n_q, hi_n_d;
  logic lo_n_q, lo_n_d;
  logic pass_q, pass_d;
  logic rd_q, rd_d;
  logic hd7_q, hd7_d;
  logic dd7_q, dd7_d;

  always_comb
  begin
    cs0_n_d = idd_pkg::OUT_INACTIVE;
    cs1_n_d = idd_pkg::OUT_INACTIVE;
    hi_n_d = idd_pkg::OUT_INACTIVE;
    lo_n_d = idd_pkg::OUT_INACTIVE;
    pass_d = 1'b0;
    rd_d = rd_cyc;
    hd7_d = hd7_s;
    dd7_d = dd7_s;
    if (rst_n && ide_enable && cyc_valid)
    begin
      if (op_mode == idd_pkg::MODE_AT)
      begin
        cs0_n_d = !cmd_hit;
        cs1_n_d = !ctl_hit;
      end
      if (cmd_hit || ctl_hit)
      begin
        lo_n_d = 1'b0;
        hi_n_d = iocs16_n_s;
      end
      pass_d = cmd_hit || ctl_lo_hit;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    cs0_n_q <= cs0_n_d;
    cs1_n_q <= cs1_n_d;
    hi_n_q <= hi_n_d;
    lo_n_q <= lo_n_d;
    pass_q <= pass_d;
    rd_q <= rd_d;
    hd7_q <= hd7_d;
    dd7_q <= dd7_d;
  end

  assign drive_chip_select_0_n = cs0_n_q;
  assign drive_chip_select_1_n = cs1_n_q;
  assign high_byte_latch_enable_n = hi_n_q;
  assign low_byte_latch_enable_n = lo_n_q;
  // bit 7 pass-through direction
  assign drive_data_bit7_out = hd7_q;
  assign drive_data_bit7_oe_n = !(pass_q && !rd_q);
  assign host_d7_out = dd7_q;
  assign host_d7_oe_n = !(pass_q && rd_q);

  // ==========================================
  // assertions
  property p_cs0_decode;
    @(posedge ref_clk) disable iff (!rst_n)
      (ide_enable && op_mode == idd_pkg::MODE_AT && cyc_valid && cmd_hit)
        |=> !drive_chip_select_0_n;
  endproperty
  a_cs0_decode: assert property (p_cs0_decode) else $error("cs0 not asserted");

  property p_cs1_decode;
    @(posedge ref_clk) disable iff (!rst_n)
      (ide_enable && op_mode == idd_pkg::MODE_AT && cyc_valid && ctl_hit)
        |=> !drive_chip_select_1_n;
  endproperty
  a_cs1_decode: assert property (p_cs1_decode) else $error("cs1 not asserted");

  property p_at_only;
    @(posedge ref_clk) disable iff (!rst_n)
      ($past(op_mode) != idd_pkg::MODE_AT) |-> (drive_chip_select_0_n && drive_chip_select_1_n);
  endproperty
  a_at_only: assert property (p_at_only) else $error("select outside at mode");

  property p_disabled;
    @(posedge ref_clk) disable iff (!rst_n)
      !ide_enable |=> (drive_chip_select_0_n && drive_chip_select_1_n &&
                       high_byte_latch_enable_n && low_byte_latch_enable_n);
  endproperty
  a_disabled: assert property (p_disabled) else $error("output active while disabled");

  property p_float_ctl_hi;
    @(posedge ref_clk) disable iff (!rst_n)
      (cyc_valid && addr_s == ctl_hi) |=> (drive_data_bit7_oe_n && host_d7_oe_n);
  endproperty
  a_float_ctl_hi: assert property (p_float_ctl_hi) else $error("bit 7 driven at 3F7");

  property p_pass_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (ide_enable && cyc_valid && !rd_cyc && (cmd_hit || ctl_lo_hit)) |=> !drive_data_bit7_oe_n;
  endproperty
  a_pass_write: assert property (p_pass_write) else $error("bit 7 not passed");

  property p_pass_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (ide_enable && cyc_valid && rd_cyc && (cmd_hit || ctl_lo_hit)) |=> !host_d7_oe_n;
  endproperty
  a_pass_read: assert property (p_pass_read) else $error("bit 7 not returned");

  property p_hi_iocs16;
    @(posedge ref_clk) disable iff (!rst_n)
      !high_byte_latch_enable_n |-> !$past(iocs16_n_s) && !low_byte_latch_enable_n;
  endproperty
  a_hi_iocs16: assert property (p_hi_iocs16) else $error("high latch without iocs16");

  property p_lo_access;
    @(posedge ref_clk) disable iff (!rst_n)
      (ide_enable && cyc_valid && (cmd_hit || ctl_hit)) |=> !low_byte_latch_enable_n;
  endproperty
  a_lo_access: assert property (p_lo_access) else $error("low latch missing");

  property p_valid_only;
    @(posedge ref_clk) disable iff (!rst_n)
      !cyc_valid |=> (drive_chip_select_0_n && drive_chip_select_1_n);
  endproperty
  a_valid_only: assert property (p_valid_only) else $error("select without cycle");

  c_cs0: cover property (@(posedge ref_clk) disable iff (!rst_n) !drive_chip_select_0_n);
  c_cs1: cover property (@(posedge ref_clk) disable iff (!rst_n) !drive_chip_select_1_n);
  c_hi: cover property (@(posedge ref_clk) disable iff (!rst_n) !high_byte_latch_enable_n);
  c_rd: cover property (@(posedge ref_clk) disable iff (!rst_n) !host_d7_oe_n);
endmodule : idd_decode

// ---- idd_drive_model.sv ----
// drive-side model: bit 7 source and 16-bit answer
`timescale 1ns/1ps
module idd_drive_model (
  input wire logic ref_clk,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic rd_n,
  input wire logic strobe_on,
  input wire logic wide,
  input wire logic d7_val,
  input wire logic host_oe_n,
  input wire logic host_bit,
  output logic iocs16_n,
  output logic d7
);
  logic flip_q = 1'h0;
  // ==========
  // pin levels
  always_ff @(posedge ref_clk)
  begin
    flip_q <= ~flip_q;
  end
  // the line never holds a stale value while nobody drives it
  assign d7 = !host_oe_n ? host_bit : (!(cs0_n && cs1_n) && !rd_n) ? d7_val : flip_q;
  assign iocs16_n = !(wide && strobe_on);
endmodule : idd_drive_model

// ---- idd_decode_bench.sv ----
// testbench for the ide drive select decoder
`timescale 1ns/1ps
module idd_decode_bench;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [9:0] host_addr = 10'h000;
  logic host_ior_n = 1'h1;
  logic host_iow_n = 1'h1;
  logic host_aen = 1'h0;
  logic host_d7_in = 1'h0;
  logic ide_enable = 1'h1;
  logic secondary_sel = 1'h0;
  idd_pkg::idd_mode_type op_mode = idd_pkg::MODE_AT;
  logic wide = 1'h0;
  logic d7_val = 1'h0;
  logic h7, h7_oe_n, d7_in, d7_out, d7_oe_n, io16_n, cs0_n, cs1_n, hi_n, lo_n;
  logic [5:0] outs;
  int mismatches = 0;
  int check_count = 0;
  // ==========
  // clock and instances
  always #5 ref_clk = ~ref_clk;
  assign outs = {cs0_n, cs1_n, hi_n, lo_n, h7_oe_n, d7_oe_n};
  idd_decode idd_decode_i (.ref_clk(ref_clk), .rst_n(rst_n), .host_addr(host_addr),
    .host_ior_n(host_ior_n), .host_iow_n(host_iow_n), .host_aen(host_aen),
    .host_d7_in(host_d7_in), .host_d7_out(h7), .host_d7_oe_n(h7_oe_n),
    .drive_data_bit7_in(d7_in), .drive_data_bit7_out(d7_out),
    .drive_data_bit7_oe_n(d7_oe_n), .drive_iocs16_n(io16_n), .ide_enable(ide_enable),
    .secondary_sel(secondary_sel), .op_mode(op_mode), .drive_chip_select_0_n(cs0_n),
    .drive_chip_select_1_n(cs1_n), .high_byte_latch_enable_n(hi_n),
    .low_byte_latch_enable_n(lo_n));
  idd_drive_model idd_drive_model_i (.ref_clk(ref_clk), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .rd_n(host_ior_n), .strobe_on(!(host_ior_n && host_iow_n)), .wide(wide),
    .d7_val(d7_val), .host_oe_n(d7_oe_n), .host_bit(d7_out), .iocs16_n(io16_n), .d7(d7_in));
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %b expected %b", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic access(input logic [9:0] a, input logic rd);
    logic cmd, ctl, en, at, pass;
    logic [5:0] exp;
    cmd = (a & idd_pkg::CMD_MASK) ==
      (secondary_sel ? idd_pkg::SEC_CMD_BASE : idd_pkg::PRI_CMD_BASE);
    ctl = a == (secondary_sel ? idd_pkg::SEC_CTL_LO : idd_pkg::PRI_CTL_LO)
      || a == (secondary_sel ? idd_pkg::SEC_CTL_HI : idd_pkg::PRI_CTL_HI);
    en = ide_enable && !host_aen;
    at = op_mode == idd_pkg::MODE_AT;
    pass = en && (cmd || (ctl && !a[0]));
    exp = {!(en && at && cmd), !(en && at && ctl), !(en && (cmd || ctl) && wide),
      !(en && (cmd || ctl)), !(pass && rd), !(pass && !rd)};
    d7_val = !d7_val;
    host_addr = a;
    host_d7_in = !d7_val;
    host_ior_n = !rd;
    host_iow_n = rd;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check(outs, exp);
    if (!exp[0])
      check({5'h00, d7_out}, {5'h00, host_d7_in});
    repeat (4) @(negedge ref_clk);
    if (!exp[1] && at)
      check({5'h00, h7}, {5'h00, d7_val});
    host_ior_n = 1'h1;
    host_iow_n = 1'h1;
    repeat (4) @(negedge ref_clk);
    check(outs, 6'h3F);
  endtask : access
  task automatic t_decode();
    logic [9:0] tab [6] = '{10'h1F0, 10'h1F7, 10'h1EF, 10'h1F8, 10'h3F6, 10'h3F7};
    for (int i = 0; i < 96; i++)
    begin
      secondary_sel = i[0];
      wide = i[2];
      access(i[3] ? tab[i / 16] & 10'h37F : tab[i / 16], i[1]);
    end
    secondary_sel = 1'h0;
  endtask : t_decode
  task automatic t_modes();
    for (int m = 1; m < 4; m++)
    begin
      op_mode = idd_pkg::idd_mode_type'(m[1:0]);
      access(10'h1F0, 1'h0);
      access(10'h3F6, 1'h1);
    end
    op_mode = idd_pkg::MODE_AT;
  endtask : t_modes
  task automatic t_off();
    ide_enable = 1'h0;
    access(10'h1F0, 1'h1);
    access(10'h3F6, 1'h0);
    ide_enable = 1'h1;
  endtask : t_off
  task automatic t_invalid();
    host_aen = 1'h1;
    access(10'h1F0, 1'h0);
    host_aen = 1'h0;
    host_ior_n = 1'h0;
    host_iow_n = 1'h0;
    repeat (5) @(negedge ref_clk);
    check(outs, 6'h3F);
    access(10'h1F0, 1'h1);
  endtask : t_invalid
  task automatic t_reset();
    wide = 1'h1;
    host_addr = 10'h1F0;
    host_ior_n = 1'h0;
    host_iow_n = 1'h1;
    repeat (4) @(negedge ref_clk);
    check(outs, 6'h11);
    rst_n = 1'h0;
    repeat (3) @(negedge ref_clk);
    check(outs, 6'h3F);
    rst_n = 1'h1;
    repeat (2) @(negedge ref_clk);
    check(outs, 6'h3F);
    @(negedge ref_clk);
    check(outs, 6'h11);
    host_ior_n = 1'h1;
    repeat (4) @(negedge ref_clk);
    check(outs, 6'h3F);
  endtask : t_reset
  initial
  begin
    repeat (12) @(negedge ref_clk);
    check(outs, 6'h3F);
    rst_n = 1'h1;
    t_decode();
    t_modes();
    t_off();
    t_invalid();
    t_reset();
    stop_test();
  end
  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule : idd_decode_bench
